// ### verilog/pnd_regs.svh
`ifndef PND_REGS_SVH
`define PND_REGS_SVH
// ---------------------------------------------
// Register indices (byte address = 4 * index)
// ---------------------------------------------
`define PND_IDX_RSVD0    4'h0
`define PND_IDX_RSVD1    4'h1
`define PND_IDX_KEYS_A   4'h2
`define PND_IDX_KEYS_B   4'h3
`define PND_IDX_KEYS_C   4'h4
`define PND_IDX_SWITCH   4'h5
`define PND_IDX_ERR      4'h8
`define PND_IDX_CTRL     4'h9
`define PND_IDX_STAT     4'hA
// ---------------------------------------------
// Error flag positions
// ---------------------------------------------
`define PND_ERR_DATA     0
`define PND_ERR_ACCESS   1
`define PND_ERR_FILL     2
`define PND_ERR_SIZE     3
`define PND_ERR_COMM     4
`define PND_ERR_FW       5
`define PND_ERR_HWINFO   6
`define PND_ERR_SERIAL   7
`define PND_ERR_MAC      8
`define PND_ERR_NOBOOT   9
`define PND_ERR_BOOTSUM  10
`define PND_ERR_KEYS     11
`define PND_ERR_DISP     12
`define PND_ERR_W        13
// ---------------------------------------------
// Control bits, reset value and self-test patterns
// ---------------------------------------------
`define PND_CTRL_START   0
`define PND_CTRL_FREEZE  1
`define PND_CTRL_RST     2'h0
`define PND_ACCESS_PAT   8'hA5
`define PND_ADDR_PAT     8'h10
`endif

// ### verilog/pnd_pkg.sv
`default_nettype none
package pnd_pkg;
    // Self-test sequencer states
    typedef enum logic [3:0] {
        PND_ST_DATA   = 4'b0000,
        PND_ST_ADDR_W = 4'b0001,
        PND_ST_ADDR_R = 4'b0010,
        PND_ST_ACC_W  = 4'b0011,
        PND_ST_ACC_R  = 4'b0100,
        PND_ST_FILL_W = 4'b0101,
        PND_ST_FILL_R = 4'b0110,
        PND_ST_CHECK  = 4'b0111,
        PND_ST_DONE   = 4'b1000
    } pnd_state_e;
    typedef logic [7:0] pnd_byte_t;
endpackage : pnd_pkg
`default_nettype wire

// ### verilog/pnd_top.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pnd_regs.svh"
module pnd_top #(
    parameter int AW       = 4,   // Working memory address bits
    parameter int EXP_SIZE = 16   // Expected memory size in words
) (
    input  wire logic            clk_sys_i,
    input  wire logic            resetn_i,
    // APB slave
    input  wire logic            psel_i,
    input  wire logic            penable_i,
    input  wire logic            pwrite_i,
    input  wire logic [7:0]      paddr_i,
    input  wire logic [31:0]     pwdata_i,
    output logic      [31:0]     prdata_o,
    output logic                 pready_o,
    output logic                 pslverr_o,
    // Operator keys, high while pressed
    input  wire logic            key_feed_start_i,
    input  wire logic            free_key_2_i,
    input  wire logic            key_auto_i,
    input  wire logic            key_nc_stop_i,
    input  wire logic            key_spindle_stop_i,
    input  wire logic            key_feed_stop_i,
    input  wire logic            free_key_1_i,
    input  wire logic            key_jog_i,
    input  wire logic            free_key_3_i,
    input  wire logic            key_handwheel_i,
    input  wire logic            key_axis4_i,
    input  wire logic            key_z_i,
    input  wire logic            key_y_i,
    input  wire logic            key_x_i,
    input  wire logic            key_nc_start_i,
    input  wire logic            key_spindle_start_i,
    input  wire logic            key_dir_minus_i,
    input  wire logic            key_rapid_i,
    input  wire logic            key_dir_plus_i,
    input  wire logic            free_key_4_i,
    // Switches and display
    input  wire logic            keyswitch_i,
    input  wire logic [4:0]      override_pos_i,
    input  wire logic            disp_ack_i,
    input  wire logic            disp_status_ok_i,
    // Self-test sources
    input  wire logic [7:0]      mem_stuck_i,
    input  wire logic [15:0]     mem_size_i,
    input  wire logic            spi_err_i,
    input  wire logic            fw_sum_ok_i,
    input  wire logic            hwinfo_ok_i,
    input  wire logic            serial_set_i,
    input  wire logic            mac_set_i,
    input  wire logic            boot_present_i,
    input  wire logic            boot_sum_ok_i,
    output logic                 selftest_done_o,
    output logic                 selftest_fail_o
);
    import pnd_pkg::*;

    // ---------------------------------------------
    // Override switch code
    // ---------------------------------------------
    // Positions above 18 have no detent; report 00000
    function automatic logic [4:0] pnd_ovr_code(
        input logic [4:0] pos
    );
        logic [4:0] c;
        c = 5'h00;
        case (pos)
            5'd0:    c = 5'b00001;
            5'd1:    c = 5'b00011;
            5'd2:    c = 5'b00010;
            5'd3:    c = 5'b00110;
            5'd4:    c = 5'b00111;
            5'd5:    c = 5'b00101;
            5'd6:    c = 5'b00100;
            5'd7:    c = 5'b01100;
            5'd8:    c = 5'b01101;
            5'd9:    c = 5'b01111;
            5'd10:   c = 5'b01110;
            5'd11:   c = 5'b01010;
            5'd12:   c = 5'b01011;
            5'd13:   c = 5'b01001;
            5'd14:   c = 5'b01000;
            5'd15:   c = 5'b11000;
            5'd16:   c = 5'b11001;
            5'd17:   c = 5'b11011;
            5'd18:   c = 5'b11010;
            default: c = 5'b00000;
        endcase
        return c;
    endfunction : pnd_ovr_code

    // ---------------------------------------------
    // Input image assembly
    // ---------------------------------------------
    pnd_byte_t next_keys_a;   // Byte 2 content
    pnd_byte_t next_keys_b;   // Byte 3 content
    pnd_byte_t next_keys_c;   // Byte 4 content
    pnd_byte_t next_switch;   // Byte 5 content
    pnd_byte_t keys_a;        // Sampled image bytes
    pnd_byte_t keys_b;
    pnd_byte_t keys_c;
    pnd_byte_t switch_st;
    logic      any_key;       // Some key pressed

    assign next_keys_a = {key_feed_start_i, free_key_2_i, key_auto_i,
                          key_nc_stop_i, key_spindle_stop_i,
                          key_feed_stop_i, free_key_1_i,
                          key_jog_i};
    assign next_keys_b = {free_key_3_i, key_handwheel_i, key_axis4_i,
                          key_z_i, key_y_i, key_x_i, key_nc_start_i,
                          key_spindle_start_i};
    // Low nibble has no key behind it
    assign next_keys_c = {key_dir_minus_i, key_rapid_i, key_dir_plus_i,
                          free_key_4_i, 4'h0};
    assign next_switch = {disp_ack_i, keyswitch_i,
                          pnd_ovr_code(override_pos_i),
                          1'b0};
    assign any_key = (|next_keys_a) | (|next_keys_b) | (|next_keys_c);

    // ---------------------------------------------
    // APB decode
    // ---------------------------------------------
    logic [3:0]  idx;       // Register index
    logic        setup;     // Setup phase of a transfer
    logic        wr_acc;    // Write completes this edge
    logic        hit;       // Address is mapped
    logic        aligned;   // Address bits 1:0 and 7:6 are zero
    logic [31:0] rd_mux;    // Read data selected
    logic [1:0]  ctrl;      // Control register
    logic [`PND_ERR_W-1:0] err;  // Sticky error flags
    logic        busy;      // Self-test running

    assign idx     = paddr_i[5:2];
    assign aligned = (paddr_i[1:0] == 2'h0) && (paddr_i[7:6] == 2'h0);
    assign setup   = psel_i & ~penable_i;
    assign wr_acc  = psel_i & penable_i & pwrite_i & hit;
    assign hit     = aligned && (idx <= `PND_IDX_SWITCH ||
                     idx == `PND_IDX_ERR || idx == `PND_IDX_CTRL ||
                     idx == `PND_IDX_STAT);
    // Zero wait states: each access phase ends at its first edge
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            // Reserved image bytes read as zero
            `PND_IDX_RSVD0:  rd_mux = 32'h0000_0000;
            `PND_IDX_RSVD1:  rd_mux = 32'h0000_0000;
            `PND_IDX_KEYS_A: rd_mux = {24'h00_0000, keys_a};
            `PND_IDX_KEYS_B: rd_mux = {24'h00_0000, keys_b};
            `PND_IDX_KEYS_C: rd_mux = {24'h00_0000, keys_c};
            `PND_IDX_SWITCH: rd_mux = {24'h00_0000, switch_st};
            `PND_IDX_ERR:    rd_mux = {19'h0_0000, err};
            `PND_IDX_CTRL:   rd_mux = {30'h0000_0000, ctrl};
            `PND_IDX_STAT:   rd_mux = {30'h0000_0000, busy,
                                       selftest_fail_o};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is latched in setup so it stands in the access phase
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup) begin
            prdata_o <= (hit && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------------------------------------
    // Control register and image sampling
    // ---------------------------------------------
    logic start_req;   // Software restart of the self-test
    assign start_req = wr_acc && idx == `PND_IDX_CTRL &&
                       pwdata_i[`PND_CTRL_START];

    // Start bit self-clears; freeze holds the image steady for reads
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl <= `PND_CTRL_RST;
        end else if (wr_acc && idx == `PND_IDX_CTRL) begin
            ctrl <= {pwdata_i[`PND_CTRL_FREEZE], 1'b0};
        end
    end

    // Image refreshes every cycle unless frozen
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            keys_a    <= 8'h00;
            keys_b    <= 8'h00;
            keys_c    <= 8'h00;
            switch_st <= 8'h00;
        end else if (!ctrl[`PND_CTRL_FREEZE]) begin
            keys_a    <= next_keys_a;
            keys_b    <= next_keys_b;
            keys_c    <= next_keys_c;
            switch_st <= next_switch;
        end
    end

    // ---------------------------------------------
    // Working memory under test
    // ---------------------------------------------
    localparam int DEPTH = 1 << AW;
    pnd_byte_t   mem [DEPTH];     // Memory array
    logic [AW-1:0] m_addr;        // Test address
    pnd_byte_t   m_wdata;         // Test write data
    logic        m_we;            // Test write strobe
    pnd_byte_t   m_rdata;         // Read data with injected faults

    // Stuck bits model a shorted data line for the test to find
    assign m_rdata = mem[m_addr] | mem_stuck_i;

    always_ff @(posedge clk_sys_i) begin
        if (m_we) begin
            mem[m_addr] <= m_wdata;
        end
    end

    // ---------------------------------------------
    // Self-test sequencer
    // ---------------------------------------------
    pnd_state_e    st;          // Current state
    pnd_state_e    next_st;     // Next state
    logic [AW:0]   cnt;         // Step counter
    logic          ph;          // Write or compare phase
    logic          last;        // Final step of this state
    logic          mism;        // Read-back mismatch
    pnd_byte_t     expect_d;    // Expected read-back
    logic [`PND_ERR_W-1:0] fail_set;  // Errors found this cycle

    assign busy = (st != PND_ST_DONE);

    // Address, data and expectation of each state
    always_comb begin
        m_addr   = '0;
        m_wdata  = 8'h00;
        m_we     = 1'b0;
        expect_d = 8'h00;
        last     = 1'b0;
        case (st)
            PND_ST_DATA: begin
                // Walking one over every data line of word 0
                expect_d = 8'h01 << cnt[2:0];
                m_wdata  = expect_d;
                m_we     = ~ph;
                last     = ph && cnt[2:0] == 3'h7;
            end
            PND_ST_ADDR_W: begin
                // Distinct value at each power-of-two address
                m_addr  = AW'(1) << cnt[AW-1:0];
                m_wdata = `PND_ADDR_PAT + 8'(cnt);
                m_we    = 1'b1;
                last    = cnt == (AW + 1)'(AW - 1);
            end
            PND_ST_ADDR_R: begin
                m_addr   = AW'(1) << cnt[AW-1:0];
                expect_d = `PND_ADDR_PAT + 8'(cnt);
                last     = cnt == (AW + 1)'(AW - 1);
            end
            PND_ST_ACC_W: begin
                m_addr  = '1;
                m_wdata = `PND_ACCESS_PAT;
                m_we    = 1'b1;
                last    = 1'b1;
            end
            PND_ST_ACC_R: begin
                m_addr   = '1;
                expect_d = `PND_ACCESS_PAT;
                last     = 1'b1;
            end
            PND_ST_FILL_W: begin
                // Inverted address pattern catches aliasing
                m_addr  = cnt[AW-1:0];
                m_wdata = ~8'(cnt);
                m_we    = 1'b1;
                last    = cnt == (AW + 1)'(DEPTH - 1);
            end
            PND_ST_FILL_R: begin
                m_addr   = cnt[AW-1:0];
                expect_d = ~8'(cnt);
                last     = cnt == (AW + 1)'(DEPTH - 1);
            end
            default: begin
                last = 1'b1;
            end
        endcase
    end

    assign mism = (m_rdata != expect_d);

    // Errors found in the current cycle
    always_comb begin
        fail_set = '0;
        fail_set[`PND_ERR_COMM] = spi_err_i;
        case (st)
            PND_ST_DATA:   fail_set[`PND_ERR_DATA]   = ph & mism;
            // Address faults share the data-line flag
            PND_ST_ADDR_R: fail_set[`PND_ERR_DATA]   = mism;
            PND_ST_ACC_R:  fail_set[`PND_ERR_ACCESS] = mism;
            PND_ST_FILL_R: fail_set[`PND_ERR_FILL]   = mism;
            PND_ST_CHECK: begin
                fail_set[`PND_ERR_SIZE] =
                    mem_size_i != 16'(EXP_SIZE);
                fail_set[`PND_ERR_FW]      = ~fw_sum_ok_i;
                fail_set[`PND_ERR_HWINFO]  = ~hwinfo_ok_i;
                fail_set[`PND_ERR_SERIAL]  = ~serial_set_i;
                fail_set[`PND_ERR_MAC]     = ~mac_set_i;
                fail_set[`PND_ERR_NOBOOT]  = ~boot_present_i;
                // A checksum only means something if a loader exists
                fail_set[`PND_ERR_BOOTSUM] =
                    boot_present_i & ~boot_sum_ok_i;
                fail_set[`PND_ERR_KEYS]    = any_key;
                fail_set[`PND_ERR_DISP]    = ~disp_status_ok_i;
                fail_set[`PND_ERR_COMM]    = spi_err_i;
            end
            default: fail_set[`PND_ERR_COMM] = spi_err_i;
        endcase
    end

    // State order
    always_comb begin
        next_st = st;
        case (st)
            PND_ST_DATA:   next_st = last ? PND_ST_ADDR_W : st;
            PND_ST_ADDR_W: next_st = last ? PND_ST_ADDR_R : st;
            PND_ST_ADDR_R: next_st = last ? PND_ST_ACC_W : st;
            PND_ST_ACC_W:  next_st = PND_ST_ACC_R;
            PND_ST_ACC_R:  next_st = PND_ST_FILL_W;
            PND_ST_FILL_W: next_st = last ? PND_ST_FILL_R : st;
            PND_ST_FILL_R: next_st = last ? PND_ST_CHECK : st;
            PND_ST_CHECK:  next_st = PND_ST_DONE;
            PND_ST_DONE:   next_st = start_req ? PND_ST_DATA : st;
            default:       next_st = PND_ST_DONE;
        endcase
    end

    // Sequencer registers; a restart is ignored while busy
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st  <= PND_ST_DATA;
            cnt <= '0;
            ph  <= 1'b0;
        end else begin
            st <= next_st;
            if (st == PND_ST_DATA && !ph) begin
                ph <= 1'b1;
            end else begin
                ph  <= 1'b0;
                cnt <= (next_st != st) ? '0 : cnt + 1'b1;
            end
        end
    end

    // ---------------------------------------------
    // Error flags
    // ---------------------------------------------
    logic [`PND_ERR_W-1:0] err_clr;   // Write-one-to-clear mask
    assign err_clr = (wr_acc && idx == `PND_IDX_ERR) ?
                     pwdata_i[`PND_ERR_W-1:0] : '0;

    // A new failure in the clearing cycle is kept: set beats clear
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            err <= '0;
        end else begin
            err <= (err & ~err_clr) | fail_set;
        end
    end

    assign selftest_done_o = ~busy;
    assign selftest_fail_o = |err;

endmodule : pnd_top
`default_nettype wire

// ### tb/pnd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pnd_checker (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        key_feed_start_i,
    input wire logic        key_jog_i,
    input wire logic        key_dir_minus_i,
    input wire logic        free_key_4_i,
    input wire logic        disp_ack_i,
    input wire logic        keyswitch_i,
    input wire logic        spi_err_i,
    input wire logic        selftest_done_o,
    input wire logic        selftest_fail_o
);
    // ----------------------------------------
    // Common clocking and read decode
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    wire rd_acc = psel_i && penable_i && !pwrite_i;  // Read access phase
    // Image lags inputs by one flop, prdata by one more
    a_ready_high: assert property (psel_i && penable_i |-> pready_o)
        else $error("access phase without ready");
    a_misalign_err: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o)
        else $error("misaligned access not refused");
    a_rsvd_zero: assert property (rd_acc && paddr_i[7:3] == 5'h00 && paddr_i[1:0] == 2'h0
        |-> prdata_o == 32'h0000_0000) else $error("reserved byte not zero");
    a_keys_a_map: assert property (rd_acc && paddr_i == 8'h08 && $past(resetn_i, 2)
        |-> prdata_o[7] == $past(key_feed_start_i, 2) && prdata_o[0] == $past(key_jog_i, 2))
        else $error("key byte a mismatch");
    a_keys_c_map: assert property (rd_acc && paddr_i == 8'h10 && $past(resetn_i, 2)
        |-> prdata_o[7] == $past(key_dir_minus_i, 2) && prdata_o[4] == $past(free_key_4_i, 2)
        && prdata_o[3:0] == 4'h0) else $error("key byte c mismatch");
    a_switch_map: assert property (rd_acc && paddr_i == 8'h14 && $past(resetn_i, 2)
        |-> prdata_o[7] == $past(disp_ack_i, 2) && prdata_o[6] == $past(keyswitch_i, 2)
        && !prdata_o[0]) else $error("switch byte mismatch");
    a_spi_err_flag: assert property (spi_err_i |=> selftest_fail_o)
        else $error("link error not flagged");
    a_keys_at_check: assert property ($rose(selftest_done_o) && $past(key_jog_i)
        |-> selftest_fail_o) else $error("pressed key not flagged");
    a_test_runs: assert property ($rose(resetn_i) |-> !selftest_done_o [*8])
        else $error("self-test skipped after reset");
    // ----------------------------------------
    // Coverage of main scenarios
    // ----------------------------------------
    c_switch_read: cover property (rd_acc && paddr_i == 8'h14);
    c_fail_done: cover property ($rose(selftest_done_o) && selftest_fail_o);
    c_spi_err: cover property (spi_err_i);
endmodule : pnd_checker
bind pnd_top pnd_checker u_chk (.*);
`default_nettype wire

// ### tb/pnd_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller view: reads the switch code, yields the override percentage.
// Offsets are relative to a base the controller picks; zero here
// Key routing to the machine is left to user code on this side
module pnd_plc_model (
    input  wire logic [4:0] code_i,
    output logic      [6:0] percent_o
);
    // ----------------------------------------
    // Position tables
    // ----------------------------------------
    localparam logic [4:0] CODES [19] = '{5'h01, 5'h03, 5'h02, 5'h06, 5'h07, 5'h05, 5'h04,
        5'h0c, 5'h0d, 5'h0f, 5'h0e, 5'h0a, 5'h0b, 5'h09, 5'h08, 5'h18, 5'h19, 5'h1b, 5'h1a};
    localparam logic [6:0] PCTS [19] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0a,
        7'h14, 7'h1e, 7'h28, 7'h32, 7'h3c, 7'h46, 7'h4b, 7'h50, 7'h55, 7'h5a, 7'h5f, 7'h64};
    // Unknown codes read as zero percent, the safe side
    always_comb begin
        percent_o = 7'h00;
        for (int i = 0; i < 19; i++) begin
            if (code_i == CODES[i]) percent_o = PCTS[i];
        end
    end
endmodule : pnd_plc_model
`default_nettype wire

// ### tb/test_pendant_input_image_and_selftest.sv
`timescale 1ns/1ps
`default_nettype none
module test_pendant_input_image_and_selftest;
    import pnd_pkg::*;
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00, mem_stuck_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd, tmp;
    logic pready_o, pslverr_o, selftest_done_o, selftest_fail_o, er;
    logic [19:0] k = 20'h0_0000;  // Packed key states, image bit order
    logic key_feed_start_i, free_key_2_i, key_auto_i, key_nc_stop_i, key_spindle_stop_i,
        key_feed_stop_i, free_key_1_i, key_jog_i, free_key_3_i, key_handwheel_i, key_axis4_i,
        key_z_i, key_y_i, key_x_i, key_nc_start_i, key_spindle_start_i, key_dir_minus_i,
        key_rapid_i, key_dir_plus_i, free_key_4_i;
    logic keyswitch_i = 1'b0, disp_ack_i = 1'b0, disp_status_ok_i = 1'b1, spi_err_i = 1'b0;
    logic fw_sum_ok_i = 1'b1, hwinfo_ok_i = 1'b1, serial_set_i = 1'b1, mac_set_i = 1'b1;
    logic boot_present_i = 1'b1, boot_sum_ok_i = 1'b1;
    logic [4:0] override_pos_i = 5'h00;
    logic [15:0] mem_size_i = 16'h0010;
    logic [6:0] pct;
    int seed = 50321, compares = 0, miscompares = 0, cyc = 0;
    localparam logic [4:0] CODES [19] = '{5'h01, 5'h03, 5'h02, 5'h06, 5'h07, 5'h05, 5'h04,
        5'h0c, 5'h0d, 5'h0f, 5'h0e, 5'h0a, 5'h0b, 5'h09, 5'h08, 5'h18, 5'h19, 5'h1b, 5'h1a};
    assign {key_dir_minus_i, key_rapid_i, key_dir_plus_i, free_key_4_i, free_key_3_i,
        key_handwheel_i, key_axis4_i, key_z_i, key_y_i, key_x_i, key_nc_start_i,
        key_spindle_start_i, key_feed_start_i, free_key_2_i, key_auto_i, key_nc_stop_i,
        key_spindle_stop_i, key_feed_stop_i, free_key_1_i, key_jog_i} = k;
    pnd_top DUT (.*);
    pnd_plc_model PLC (.code_i(rd[5:1]), .percent_o(pct));
    always #2.5 clk_sys_i = ~clk_sys_i;
    // Whole run needs about 1200 cycles; the ceiling leaves slack
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Bus and helper tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wait_done();
        int n = 0;
        @(posedge clk_sys_i);
        while (selftest_done_o !== 1'b1 && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        `CHK("selftest done", 1'b1, selftest_done_o)
    endtask : wait_done
    // Inject one fault kind, or take it away again
    task automatic set_fault(input int j, input logic on);
        case (j)
            0: mem_stuck_i <= on ? 8'h02 : 8'h00;  // Bit 1 breaks lines, access and fill
            1: mem_size_i <= on ? 16'h000f : 16'h0010;
            2: spi_err_i <= on;
            3: fw_sum_ok_i <= !on;
            4: hwinfo_ok_i <= !on;
            5: serial_set_i <= !on;
            6: mac_set_i <= !on;
            7: begin  // Bad sum with no loader must not count twice
                boot_present_i <= !on;
                boot_sum_ok_i <= !on;
            end
            8: boot_sum_ok_i <= !on;
            9: k <= on ? 20'h0_0001 : 20'h0_0000;
            default: disp_status_ok_i <= !on;
        endcase
    endtask : set_fault
    // Image byte 5 as the controller should see it; no detent reads 00000
    function automatic logic [31:0] exp_switch(input logic [1:0] ak, input int p);
        return {24'h00_0000, ak, (p < 19) ? CODES[p] : 5'h00, 1'b0};
    endfunction : exp_switch
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        wait_done();
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK("healthy errors", 32'h0000_0000, rd)
        apb(1'b1, 8'h00, 32'hffff_ffff);
        apb(1'b0, 8'h00, 32'h0000_0000);
        `CHK("reserved 0", 32'h0000_0000, rd)
        apb(1'b0, 8'h04, 32'h0000_0000);
        `CHK("reserved 1", 32'h0000_0000, rd)
        apb(1'b0, 8'h02, 32'h0000_0000);
        `CHK("misaligned", 1'b1, er)
        $display("test reserved finished");
        for (int i = 0; i < 19; i++) begin
            tmp = $random(seed);
            k <= tmp[19:0];
            keyswitch_i <= tmp[20];
            disp_ack_i <= tmp[21];
            override_pos_i <= i[4:0];
            apb(1'b0, 8'h08, 32'h0000_0000);
            `CHK("keys a", {24'h00_0000, k[7:0]}, rd)
            apb(1'b0, 8'h0c, 32'h0000_0000);
            `CHK("keys b", {24'h00_0000, k[15:8]}, rd)
            apb(1'b0, 8'h10, 32'h0000_0000);
            `CHK("keys c", {24'h00_0000, k[19:16], 4'h0}, rd)
            apb(1'b0, 8'h14, 32'h0000_0000);
            `CHK("switch", exp_switch(tmp[21:20], i), rd)
            if (i == 18) `CHK("percent", 7'h64, pct)
        end
        // Freeze holds the image although every key flips
        apb(1'b1, 8'h24, 32'h0000_0002);
        k <= ~k;
        apb(1'b0, 8'h0c, 32'h0000_0000);
        `CHK("frozen keys", {24'h00_0000, ~k[15:8]}, rd)
        override_pos_i <= 5'd19;
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        `CHK("live keys", {24'h00_0000, k[15:8]}, rd)
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK("no detent", exp_switch(tmp[21:20], 19), rd)
        k <= 20'h0_0000;
        $display("test image finished");
        for (int j = 0; j < 11; j++) begin
            apb(1'b1, 8'h20, 32'h0000_1fff);
            set_fault(j, 1'b1);
            apb(1'b1, 8'h24, 32'h0000_0001);
            wait_done();
            `CHK("fail out", 1'b1, selftest_fail_o)
            set_fault(j, 1'b0);
            apb(1'b0, 8'h20, 32'h0000_0000);
            if (j == 0) `CHK("line fault", 32'h0000_0007, rd)
            else `CHK("fault flag", 32'h0000_0001 << (j + 2), rd)
            apb(1'b0, 8'h28, 32'h0000_0000);
            `CHK("status fail", 32'h0000_0001, rd)
        end
        $display("test selftest finished");
        // Reset in the middle of a run clears the flags and starts afresh
        apb(1'b1, 8'h24, 32'h0000_0001);
        repeat (9) @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        wait_done();
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK("errors after reset", 32'h0000_0000, rd)
        apb(1'b0, 8'h28, 32'h0000_0000);
        `CHK("status after reset", 32'h0000_0000, rd)
        $display("test reset finished");
        print_verdict();
    end
endmodule : test_pendant_input_image_and_selftest
`default_nettype wire
